/* pkg/sync_defines.svh */
// Constants of the sync-line master/slave logic: timing, register map and bit positions.
`ifndef SYNC_DEFINES_SVH
`define SYNC_DEFINES_SVH

`define SYNC_CLK_MHZ        100
`define SYNC_PER250_NS      4000
`define SYNC_PER500_NS      2000
`define SYNC_PER250_CYC     ((`SYNC_PER250_NS * `SYNC_CLK_MHZ) / 1000)
`define SYNC_PER500_CYC     ((`SYNC_PER500_NS * `SYNC_CLK_MHZ) / 1000)
`define SYNC_SPREAD_PCT     10
`define SYNC_TON_MIN_NS     340
`define SYNC_TON_MIN_CYC    ((`SYNC_TON_MIN_NS * `SYNC_CLK_MHZ + 999) / 1000)
`define SYNC_PWRUP_NS       10000
`define SYNC_PWRUP_CYC      ((`SYNC_PWRUP_NS * `SYNC_CLK_MHZ + 999) / 1000)
`define SYNC_FAST_PULSES    10

`define SYNC_CTRL_OFS       8'h00
`define SYNC_STATUS_OFS     8'h04
`define SYNC_GAP_OFS        8'h08
`define SYNC_CTRL_EN_BIT    0
`define SYNC_CTRL_EN_RST    1'b1
`define SYNC_ST_SLAVE_BIT   0
`define SYNC_ST_LATCH_BIT   1
`define SYNC_ST_STRAP_BIT   2
`define SYNC_ST_RUN_BIT     3
`define SYNC_ST_FAST_LSB    8

`endif

/* pkg/sync_pkg.sv */
// Types of the sync-line master/slave logic.
package sync_pkg;

  typedef enum logic [1:0] {PWRUP, MASTER, SLAVE, LATCHED} mode_t;

  typedef struct packed {
    mode_t       mode;
    logic        sync_a;
    logic        sync_b;
    logic        sync_prev;
    logic        strap_a;
    logic        strap_b;
    logic        strap;
    logic        line_low;
    logic [15:0] osc;
    logic [15:0] gap;
    logic [15:0] last_gap;
    logic [3:0]  fast;
    logic [7:0]  pulse;
    logic        sync_out;
    logic        sync_oe;
    logic        sw_start;
    logic        enable;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } state_t;

endpackage

/* src/switching_sync_master_slave.sv */
// Master/slave synchronisation of the regulator oscillator on the shared sync line.
//
// Contract
// - A slave switches 180 degrees from the master, the same offset for every slave.
// - A latched slave starts its switching cycle on each sync pulse it receives, an unlatched one only on pulses faster than the spread limit.
// - Devices following an external reference all switch in phase with it.
// - Slope compensation follows the strap captured at power-up and never changes after.
// - By default the device is master and drives sync pulses at its strapped frequency.
// - As slave the oscillator runs at nominal 250 kHz whatever the strap selects.
// - Ten consecutive received periods faster than the strap's spread limit turn the device into a slave.
// - An unlatched slave left without fast pulses drives one 250 kHz pulse and returns to master.
// - A sync line held low through power-up selects latched slave mode.
// - Latched slave runs at 250 kHz until the next undervoltage-lockout reset.
// - The frequency strap is sampled only during power-up, before switching starts.
`timescale 1ns/1ps
`include "sync_defines.svh"

module switching_sync_master_slave #(
  parameter int FAST_PULSES = `SYNC_FAST_PULSES
) (
  // Clock and undervoltage-lockout reset.
  input  wire logic        CLK_SYS,
  input  wire logic        SYS_RST,
  // Shared sync line.
  input  wire logic        SYNC_IN,
  output logic             SYNC_OUT,
  output logic             SYNC_OE,
  // Frequency selection strap.
  input  wire logic        FREQ_SELECT_STRAP,
  // Oscillator results.
  output logic             SW_START,
  output logic             SLOPE_COMP,
  output logic             SLAVE_MODE,
  output logic             LATCHED_SLAVE,
  // APB slave.
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  input  wire logic [3:0]  PSTRB,
  output logic             PREADY,
  output logic [31:0]      PRDATA,
  output logic             PSLVERR
);

  sync_pkg::state_t s;
  sync_pkg::state_t n;

  logic        rise;
  logic        echo;
  logic        fast_edge;
  logic        start_pulse;
  logic        access;
  logic [15:0] per;
  logic [15:0] nominal;
  logic [31:0] status;

  function automatic logic [15:0] osc_period(input logic strap);
    osc_period = strap ? 16'(`SYNC_PER500_CYC) : 16'(`SYNC_PER250_CYC);
  endfunction

  // Shortest period still inside the oscillator spread; anything shorter comes from outside.
  function automatic logic [15:0] fast_limit(input logic [15:0] period);
    fast_limit = 16'((32'(period) * 100) / (100 + `SYNC_SPREAD_PCT));
  endfunction

  function automatic logic mapped(input logic [7:0] addr);
    mapped = (addr == `SYNC_CTRL_OFS) || (addr == `SYNC_STATUS_OFS) ||
             (addr == `SYNC_GAP_OFS);
  endfunction

  always_comb begin
    n           = s;
    rise        = 1'b0;
    echo        = 1'b0;
    fast_edge   = 1'b0;
    start_pulse = 1'b0;
    access      = PSEL & PENABLE;
    per         = osc_period(s.strap);
    nominal     = 16'(`SYNC_PER250_CYC);
    status      = 32'h0;

    n.sync_a    = SYNC_IN;
    n.sync_b    = s.sync_a;
    n.sync_prev = s.sync_b;
    n.strap_a   = FREQ_SELECT_STRAP;
    n.strap_b   = s.strap_a;
    n.sw_start  = 1'b0;

    // Only the echo of our own rising edge is masked, through the synchroniser lag.
    // Masking the whole pulse would drop external edges that land inside it and
    // break the run of fast periods that slave detection needs.
    echo = s.sync_oe && (s.pulse > 8'(`SYNC_TON_MIN_CYC - 4));
    rise = s.sync_b & ~s.sync_prev & ~echo & s.enable;
    fast_edge = rise && (s.gap < fast_limit(per));
    if (rise) begin
      n.gap      = 16'h1;
      n.last_gap = s.gap;
    end else if (s.gap != 16'hffff) begin
      n.gap = s.gap + 16'h1;
    end

    unique case (s.mode)
      sync_pkg::PWRUP: begin
        n.osc = s.osc + 16'h1;
        if (s.sync_b) begin
          n.line_low = 1'b0;
        end
        if (s.osc == 16'(`SYNC_PWRUP_CYC - 1)) begin
          n.strap    = s.strap_b;
          n.osc      = 16'h0;
          n.sw_start = 1'b1;
          n.mode     = n.line_low ? sync_pkg::LATCHED : sync_pkg::MASTER;
        end
      end
      sync_pkg::MASTER: begin
        if (s.osc >= per - 16'h1) begin
          n.osc      = 16'h0;
          n.sw_start = 1'b1;
        end else begin
          n.osc = s.osc + 16'h1;
        end
        // The line pulse sits half a period after own switching, so followers run in antiphase.
        if (n.osc == (per >> 1)) begin
          start_pulse = 1'b1;
        end
        if (rise) begin
          if (fast_edge) begin
            n.fast = s.fast + 4'h1;
            if (s.fast == 4'(FAST_PULSES - 1)) begin
              n.mode     = sync_pkg::SLAVE;
              n.fast     = 4'h0;
              n.osc      = 16'h0;
              n.sw_start = 1'b1;
            end
          end else begin
            n.fast = 4'h0;
          end
        end
      end
      sync_pkg::SLAVE: begin
        if (fast_edge) begin
          n.osc      = 16'h0;
          n.sw_start = 1'b1;
        end else if (s.osc >= nominal - 16'h1) begin
          n.osc       = 16'h0;
          n.sw_start  = 1'b1;
          start_pulse = 1'b1;
          n.mode      = sync_pkg::MASTER;
        end else begin
          n.osc = s.osc + 16'h1;
        end
      end
      sync_pkg::LATCHED: begin
        if (rise) begin
          n.osc      = 16'h0;
          n.sw_start = 1'b1;
        end else if (s.osc >= nominal - 16'h1) begin
          n.osc       = 16'h0;
          n.sw_start  = 1'b1;
          start_pulse = 1'b1;
        end else begin
          n.osc = s.osc + 16'h1;
        end
      end
    endcase

    // Each driven pulse lasts the minimum on time, the shortest width a receiver accepts.
    if (start_pulse && s.enable) begin
      n.pulse = 8'(`SYNC_TON_MIN_CYC);
    end else if (s.pulse != 8'h0) begin
      n.pulse = s.pulse - 8'h1;
    end
    n.sync_oe  = (n.pulse != 8'h0);
    n.sync_out = n.sync_oe;

    status[`SYNC_ST_SLAVE_BIT] = (s.mode == sync_pkg::SLAVE) || (s.mode == sync_pkg::LATCHED);
    status[`SYNC_ST_LATCH_BIT] = (s.mode == sync_pkg::LATCHED);
    status[`SYNC_ST_STRAP_BIT] = s.strap;
    status[`SYNC_ST_RUN_BIT]   = (s.mode != sync_pkg::PWRUP);
    status[`SYNC_ST_FAST_LSB +: 4] = s.fast;

    // The answer is registered, which costs one wait state per transfer.
    n.pready  = access & ~s.pready;
    n.pslverr = 1'b0;
    n.prdata  = 32'h0;
    if (access && !s.pready) begin
      n.pslverr = ~mapped(PADDR);
      if (!PWRITE) begin
        unique case (PADDR)
          `SYNC_CTRL_OFS:   n.prdata = {31'h0, s.enable};
          `SYNC_STATUS_OFS: n.prdata = status;
          `SYNC_GAP_OFS:    n.prdata = {16'h0, s.last_gap};
          default:          n.prdata = 32'h0;
        endcase
      end
    end
    if (access && s.pready && PWRITE && PSTRB[0] && (PADDR == `SYNC_CTRL_OFS)) begin
      n.enable = PWDATA[`SYNC_CTRL_EN_BIT];
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      s          <= '0;
      s.enable   <= `SYNC_CTRL_EN_RST;
      s.line_low <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign SYNC_OUT      = s.sync_out;
  assign SYNC_OE       = s.sync_oe;
  assign SW_START      = s.sw_start;
  assign SLOPE_COMP    = s.strap;
  assign SLAVE_MODE    = (s.mode == sync_pkg::SLAVE) || (s.mode == sync_pkg::LATCHED);
  assign LATCHED_SLAVE = (s.mode == sync_pkg::LATCHED);
  assign PREADY        = s.pready;
  assign PRDATA        = s.prdata;
  assign PSLVERR       = s.pslverr;

endmodule

/* testbench/sync_checker.sv */
// Assertion checker on the ports of the sync master/slave block.
`timescale 1ns/1ps
module sync_checker (
  // Clock and reset.
  input wire logic        CLK_SYS,
  input wire logic        SYS_RST,
  // Sync line and oscillator.
  input wire logic        SYNC_IN,
  input wire logic        SYNC_OUT,
  input wire logic        SYNC_OE,
  input wire logic        SW_START,
  input wire logic        SLOPE_COMP,
  input wire logic        SLAVE_MODE,
  input wire logic        LATCHED_SLAVE,
  // APB answer.
  input wire logic        PREADY,
  input wire logic [31:0] PRDATA,
  input wire logic        PSLVERR
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);
  property p_oe; SYNC_OUT == SYNC_OE; endproperty
  a_oe: assert property (p_oe) else $error("drive differs");
  property p_wid; $rose(SYNC_OE) |-> ##33 SYNC_OE ##1 !SYNC_OE; endproperty
  a_wid: assert property (p_wid) else $error("pulse width");
  // The fallback pulse starts with its own cycle, so it is left out here.
  property p_ph; $rose(SYNC_OE) && !SLAVE_MODE && !$past(SLAVE_MODE, 2) |->
    (SLOPE_COMP ? $past(SW_START, 100) : $past(SW_START, 200)); endproperty
  a_ph: assert property (p_ph) else $error("master phase");
  property p_fol; $rose(SYNC_IN) && SLAVE_MODE && !SYNC_OE |-> ##[1:4] SW_START; endproperty
  a_fol: assert property (p_fol) else $error("slave follow");
  property p_slp; !$stable(SLOPE_COMP) |-> SW_START; endproperty
  a_slp: assert property (p_slp) else $error("slope changed");
  property p_lat; LATCHED_SLAVE |-> SLAVE_MODE ##1 LATCHED_SLAVE; endproperty
  a_lat: assert property (p_lat) else $error("latched left");
  property p_fb; $fell(SLAVE_MODE) |-> ##[0:2] SYNC_OE; endproperty
  a_fb: assert property (p_fb) else $error("no fallback pulse");
  property p_rdy; PREADY |=> !PREADY; endproperty
  a_rdy: assert property (p_rdy) else $error("ready too long");
  property p_idl; !PREADY |-> PRDATA == 32'h0 && !PSLVERR; endproperty
  a_idl: assert property (p_idl) else $error("idle answer");
  c_sl: cover property ($rose(SLAVE_MODE) && !LATCHED_SLAVE);
  c_lt: cover property ($rose(LATCHED_SLAVE));
  c_fb: cover property ($fell(SLAVE_MODE));
endmodule

/* testbench/sync_partner.sv */
// Behavioural external sync source that pulls the shared line low.
`timescale 1ns/1ps
module sync_partner (
  // Open-drain pull on the shared line.
  output logic line_low
);
  logic lclk = 1'b0;
  initial line_low = 1'b0;
  // Own 125 ns timebase, unrelated in phase to the system clock.
  always #62.5 lclk = ~lclk;
  task automatic hold(input logic v);
    line_low <= v;
  endtask
  // Low pulses of 375 ns, so never shorter than the minimum on time.
  task automatic burst(input int n, input int ticks);
    repeat (n) begin
      @(posedge lclk);
      line_low <= 1'b1;
      repeat (3) @(posedge lclk);
      line_low <= 1'b0;
      repeat (ticks - 4) @(posedge lclk);
    end
  endtask
endmodule

/* testbench/test_switching_sync_master_slave.sv */
// Self-checking bench of the sync master/slave block.
`timescale 1ns/1ps
`include "sync_defines.svh"
module test_switching_sync_master_slave;
  logic        CLK_SYS = 1'b0;
  logic        SYS_RST = 1'b1;
  logic        FREQ_SELECT_STRAP = 1'b0;
  logic        PSEL = 1'b0;
  logic        PENABLE = 1'b0;
  logic        PWRITE = 1'b0;
  logic [7:0]  PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0;
  logic        line_low, SYNC_OUT, SYNC_OE, SW_START, SLOPE_COMP, SLAVE_MODE, LATCHED_SLAVE;
  logic        PREADY, PSLVERR, err;
  logic [31:0] PRDATA, rd;
  int          bad_count = 0;
  int          n_checks = 0;
  int          c;
  always #5 CLK_SYS = ~CLK_SYS;
  sync_partner sync_partner_i (.line_low(line_low));
  // The line idles high on its pull-up; the device only drives it high, so it cannot change it.
  switching_sync_master_slave switching_sync_master_slave_i (.CLK_SYS(CLK_SYS),
    .SYS_RST(SYS_RST), .SYNC_IN(~line_low), .SYNC_OUT(SYNC_OUT), .SYNC_OE(SYNC_OE),
    .FREQ_SELECT_STRAP(FREQ_SELECT_STRAP), .SW_START(SW_START), .SLOPE_COMP(SLOPE_COMP),
    .SLAVE_MODE(SLAVE_MODE), .LATCHED_SLAVE(LATCHED_SLAVE), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(4'hf), .PREADY(PREADY),
    .PRDATA(PRDATA), .PSLVERR(PSLVERR));
  task automatic conclude;
    if (bad_count == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge CLK_SYS);
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= {1'b1, 1'b0, w, a, d};
    @(posedge CLK_SYS);
    PENABLE <= 1'b1;
    n = 0;
    do begin @(posedge CLK_SYS); n++; end while (PREADY !== 1'b1 && n < 50);
    if (n >= 50) begin
      bad_count++;
      $display("MISMATCH apb_ready expected 1 seen %b", PREADY);
    end
    rd = PRDATA;
    err = PSLVERR;
    {PSEL, PENABLE} <= 2'b00;
  endtask
  task automatic per(output int p);
    p = 0;
    do @(posedge CLK_SYS); while (SW_START !== 1'b1 && ++p < 2000);
    p = 0;
    do begin @(posedge CLK_SYS); p++; end while (SW_START !== 1'b1 && p < 2000);
  endtask
  task automatic rst(input logic hl, input logic st);
    sync_partner_i.hold(hl);
    FREQ_SELECT_STRAP <= st;
    SYS_RST <= 1'b1;
    repeat (5) @(posedge CLK_SYS);
    SYS_RST <= 1'b0;
    repeat (1010) @(posedge CLK_SYS);
    sync_partner_i.hold(1'b0);
  endtask
  task automatic t_latched;
    rst(1'b1, 1'b1);
    chk("latched", 32'h1, LATCHED_SLAVE);
    per(c);
    chk("latched period", 32'd400, c);
    FREQ_SELECT_STRAP <= 1'b0;
    apb(1'b0, `SYNC_STATUS_OFS, 32'h0);
    chk("status", 32'hf, rd & 32'hf);
    chk("slope", 32'h1, SLOPE_COMP);
  endtask
  task automatic t_master;
    rst(1'b0, 1'b0);
    per(c);
    chk("period 250k", 32'd400, c);
    rst(1'b0, 1'b1);
    per(c);
    chk("period 500k", 32'd200, c);
    apb(1'b0, `SYNC_CTRL_OFS, 32'h0);
    chk("ctrl reset", 32'h1, rd);
    apb(1'b1, `SYNC_CTRL_OFS, 32'h0);
    apb(1'b0, `SYNC_CTRL_OFS, 32'h0);
    chk("ctrl write", 32'h0, rd);
    apb(1'b1, `SYNC_CTRL_OFS, 32'h1);
    apb(1'b0, 8'h0c, 32'h0);
    chk("unmapped", 32'h1, {rd[30:0], err});
  endtask
  // A slow gap in the middle must throw away the fast edges counted before it.
  task automatic t_restart;
    sync_partner_i.burst(6, 12);
    sync_partner_i.burst(1, 20);
    sync_partner_i.burst(6, 12);
    chk("still master", 32'h0, SLAVE_MODE);
  endtask
  task automatic t_slave;
    sync_partner_i.burst(12, 12);
    chk("slave", 32'h1, SLAVE_MODE);
    c = 0;
    while (SW_START !== 1'b1 && c < 2000) begin @(posedge CLK_SYS); c++; end
    chk("fallback at 250k", 32'h1, c >= 298 && c <= 308);
    per(c);
    chk("back to strap", 32'd200, c);
    chk("master again", 32'h0, SLAVE_MODE);
  endtask
  initial begin
    t_latched;
    t_master;
    t_restart;
    t_slave;
    conclude;
  end
  initial begin
    #1000000;
    bad_count++;
    conclude;
  end
endmodule
bind switching_sync_master_slave sync_checker sync_checker_i (.CLK_SYS(CLK_SYS),
  .SYS_RST(SYS_RST), .SYNC_IN(SYNC_IN), .SYNC_OUT(SYNC_OUT), .SYNC_OE(SYNC_OE),
  .SW_START(SW_START), .SLOPE_COMP(SLOPE_COMP), .SLAVE_MODE(SLAVE_MODE),
  .LATCHED_SLAVE(LATCHED_SLAVE), .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR));
